// ---- hw/dio_mapper.sv ----
// drive digital input/output function mapper with apb registers
`timescale 1ns/100ps
module dio_mapper
   import dio_pkg::*;
(
   input  wire logic              MCLK,
   input  wire logic              RST_N,
   input  wire logic [11:0]       PADDR,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic [NUM_IN-1:0] DIGITAL_INPUT,
   input  wire dio_stat_t         DRIVE_STAT,
   output dio_cmd_t               DRIVE_CMD,
   output logic [1:0]             RELAY_OUT,
   output logic [3:0]             OC_OUT_O,
   output logic [3:0]             OC_OUT_OE
);

   typedef struct packed {
      logic [NUM_IN-1:0][7:0]  in_sel;
      logic [7:0]              filter;
      logic [NUM_OUT-1:0][7:0] out_sel;
      logic [1:0]              run_mode;
      logic [NUM_IN-1:0][3:0]  flt_cnt;
      logic [NUM_IN-1:0]       in_lvl;
      dio_cmd_t                cmd;
      logic [NUM_OUT-1:0]      out_act;
      logic [31:0]             rdata;
   } dio_state_t;

   dio_state_t st_ff;
   dio_state_t nxt_st;

   // all assertions below sit in the bus clock domain
   default clocking dio_cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);

   // register index of a mapped word, or 5'h1F when unmapped
   function automatic logic [4:0] reg_index(input logic [11:0] a);
      logic [4:0] r;
      r = 5'h1F;
      if (a[1:0] == 2'h0 && a <= OFS_IN_STAT)
         r = a[6:2];
      if (a == 12'h01C || (a > 12'h038 && a < OFS_RUN_MODE))
         r = 5'h1F;
      return r;
   endfunction : reg_index

   // strips the inverting offset and tells the sense
   function automatic logic [8:0] split_code(input logic [7:0] c);
      logic [8:0] r;
      r = {1'b0, c};
      if (c >= INVERT_OFS)
         r = {1'b1, c - INVERT_OFS};
      return r;
   endfunction : split_code

   // output level for one function code against drive status
   function automatic logic out_func(input logic [7:0] c, input dio_stat_t s,
                                     input logic [1:0] m);
      logic [8:0] sc;
      logic       v;
      sc = split_code(c);
      v  = 1'b0;
      unique case (sc[7:0])
         FO_READY: v = s.self_test_ok & ~s.fault;
         FO_FAULT: v = s.fault_stop;
         FO_RUN:   v = s.running;
         FO_ZERO:  v = s.running & s.zero_power;
         FO_BUSOK: v = s.bus_ok;
         FO_REGEN: v = s.regen;
         FO_ANTI:  v = s.dir_cmd;
         FO_LBRK:  v = s.lift_brake_rel & (m == MODE_LIFT);
         FO_NBRK:  v = s.norm_brake_rel & (m == MODE_NORMAL);
         default:  v = 1'b0;
      endcase
      if (sc[7:0] == 8'h00)
         return 1'b0;
      return v ^ sc[8];
   endfunction : out_func

   logic       acc_phase;
   logic [4:0] ridx;
   assign acc_phase = PSEL & PENABLE;
   assign ridx      = reg_index(PADDR);

   // next state: bus writes, input filter, command decode, output map
   always_comb begin
      logic [8:0]  sc;
      logic        act;
      logic [31:0] rd;
      sc     = 9'h000;
      act    = 1'b0;
      rd     = 32'h0000_0000;
      nxt_st = st_ff;
      // register writes on the access edge
      if (acc_phase && PWRITE && ridx != 5'h1F) begin
         if (ridx < 5'h07)
            nxt_st.in_sel[ridx[2:0]] = PWDATA[7:0];
         else if (ridx == 5'h08)
            nxt_st.filter = (PWDATA[7:0] > FILTER_MAX) ? FILTER_MAX : PWDATA[7:0];
         else if (ridx >= 5'h09 && ridx <= 5'h0E)
            nxt_st.out_sel[3'(ridx - 5'h09)] = PWDATA[7:0];
         else if (ridx == 5'h10)
            nxt_st.run_mode = PWDATA[1:0];
      end
      // per input: level held until stable for the filter count
      for (int i = 0; i < NUM_IN; i++) begin
         if (DIGITAL_INPUT[i] == st_ff.in_lvl[i])
            nxt_st.flt_cnt[i] = 4'h0;
         else if ({4'h0, st_ff.flt_cnt[i]} >= st_ff.filter) begin
            nxt_st.in_lvl[i]  = DIGITAL_INPUT[i];
            nxt_st.flt_cnt[i] = 4'h0;
         end else
            nxt_st.flt_cnt[i] = st_ff.flt_cnt[i] + 4'h1;
      end
      // command decode from filtered levels
      nxt_st.cmd = '0;
      for (int i = 0; i < NUM_IN; i++) begin
         sc  = split_code(st_ff.in_sel[i]);
         act = st_ff.in_lvl[i] ^ sc[8];
         unique case (sc[7:0])
            FI_RAMP0: nxt_st.cmd.ramp_sel[0]  |= act;
            FI_RAMP1: nxt_st.cmd.ramp_sel[1]  |= act;
            FI_SPD0:  nxt_st.cmd.speed_sel[0] |= act;
            FI_SPD1:  nxt_st.cmd.speed_sel[1] |= act;
            FI_SPD2:  nxt_st.cmd.speed_sel[2] |= act;
            FI_FWD:   nxt_st.cmd.run_fwd      |= act;
            FI_REV:   nxt_st.cmd.run_rev      |= act;
            FI_3WIRE: nxt_st.cmd.three_wire   |= act;
            FI_RST:   nxt_st.cmd.fault_reset  |= act;
            FI_EXTF:  nxt_st.cmd.ext_fault    |= act;
            FI_BLOCK: nxt_st.cmd.out_block    |= act;
            FI_ESTOP: nxt_st.cmd.emerg_stop   |= act;
            FI_LRISE: nxt_st.cmd.lift_rise |= act & (st_ff.run_mode == MODE_LIFT);
            FI_LFALL: nxt_st.cmd.lift_fall |= act & (st_ff.run_mode == MODE_LIFT);
            FI_BRAKE: nxt_st.cmd.brake_fb     |= act;
            default:  ;
         endcase
      end
      // output functions
      for (int j = 0; j < NUM_OUT; j++)
         nxt_st.out_act[j] = out_func(st_ff.out_sel[j], DRIVE_STAT, st_ff.run_mode);
      // read data captured at the setup cycle, valid in the access phase
      unique case (ridx)
         5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06:
                 rd = {24'h0, st_ff.in_sel[ridx[2:0]]};
         5'h08:  rd = {24'h0, st_ff.filter};
         5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E:
                 rd = {24'h0, st_ff.out_sel[3'(ridx - 5'h09)]};
         5'h10:  rd = {30'h0, st_ff.run_mode};
         5'h11:  rd = {17'h0, st_ff.cmd};
         5'h12:  rd = {25'h0, st_ff.in_lvl};
         default: rd = 32'h0000_0000;
      endcase
      if (PSEL && !PENABLE)
         nxt_st.rdata = rd;
   end

   // state register with synchronous reset
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         st_ff          <= '0;
         st_ff.in_sel   <= {RST_IN_SEL6, RST_IN_SEL5, RST_IN_SEL4, RST_IN_SEL3,
                            RST_IN_SEL2, RST_IN_SEL1, RST_IN_SEL0};
         st_ff.filter   <= RST_FILTER;
         st_ff.out_sel  <= {RST_OUT_SELOC, RST_OUT_SELOC, RST_OUT_SELOC, RST_OUT_SELOC,
                            RST_OUT_SEL1, RST_OUT_SEL0};
         st_ff.run_mode <= RST_RUN_MODE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // bus answer: zero wait states, error on unmapped
   assign PREADY  = 1'b1;
   assign PSLVERR = acc_phase & (ridx == 5'h1F);
   assign PRDATA  = st_ff.rdata;
   assign DRIVE_CMD = st_ff.cmd;

   // pins: relays close and collectors pull low when asserted
   assign RELAY_OUT = st_ff.out_act[1:0];
   assign OC_OUT_O  = 4'h0;
   assign OC_OUT_OE = st_ff.out_act[5:2];

   // assertions
   property p_block_follows;
      @(posedge MCLK) disable iff (!RST_N)
      (st_ff.in_sel[0] == FI_BLOCK && st_ff.in_lvl[0]) |=> DRIVE_CMD.out_block;
   endproperty
   a_block_follows: assert property (p_block_follows) else $error("block missing");
   property p_inv_block;
      @(posedge MCLK) disable iff (!RST_N)
      (st_ff.in_sel[4] == 8'h76 && !st_ff.in_lvl[4]) |=> DRIVE_CMD.out_block;
   endproperty
   a_inv_block: assert property (p_inv_block) else $error("inverted block missing");
   property p_lift_gate;
      @(posedge MCLK) disable iff (!RST_N)
      ($past(st_ff.run_mode) != MODE_LIFT) |-> !DRIVE_CMD.lift_rise && !DRIVE_CMD.lift_fall;
   endproperty
   a_lift_gate: assert property (p_lift_gate) else $error("lift cmd outside lift mode");
   property p_filter_max;
      @(posedge MCLK) disable iff (!RST_N) st_ff.filter <= FILTER_MAX;
   endproperty
   a_filter_max: assert property (p_filter_max) else $error("filter above ten");
   property p_filter_hold;
      @(posedge MCLK) disable iff (!RST_N)
      (st_ff.filter == 8'h03 && $changed(DIGITAL_INPUT[0]))
         ##1 ($stable(DIGITAL_INPUT[0]))[*3] |-> $stable(st_ff.in_lvl[0]);
   endproperty
   a_filter_hold: assert property (p_filter_hold) else $error("input passed early");
   property p_fault_out;
      @(posedge MCLK) disable iff (!RST_N)
      (st_ff.out_sel[0] == FO_FAULT) |=> (RELAY_OUT[0] == $past(DRIVE_STAT.fault_stop));
   endproperty
   a_fault_out: assert property (p_fault_out) else $error("fault relay wrong");
   property p_run_inv;
      @(posedge MCLK) disable iff (!RST_N)
      (st_ff.out_sel[2] == 8'h67) |=> (OC_OUT_OE[0] == !$past(DRIVE_STAT.running));
   endproperty
   a_run_inv: assert property (p_run_inv) else $error("inverted run wrong");
   property p_oc_low;
      @(posedge MCLK) disable iff (!RST_N) OC_OUT_O == 4'h0;
   endproperty
   a_oc_low: assert property (p_oc_low) else $error("collector drives high");

   // input decode: an active terminal sets its command bit
   property p_ramp0;
      (st_ff.in_sel[0] == FI_RAMP0 && st_ff.in_lvl[0]) |=> DRIVE_CMD.ramp_sel[0];
   endproperty
   a_ramp0: assert property (p_ramp0) else $error("ramp bit 0 missing");

   property p_ramp1;
      (st_ff.in_sel[0] == FI_RAMP1 && st_ff.in_lvl[0]) |=> DRIVE_CMD.ramp_sel[1];
   endproperty
   a_ramp1: assert property (p_ramp1) else $error("ramp bit 1 missing");

   property p_spd0;
      (st_ff.in_sel[0] == FI_SPD0 && st_ff.in_lvl[0]) |=> DRIVE_CMD.speed_sel[0];
   endproperty
   a_spd0: assert property (p_spd0) else $error("speed bit 0 missing");

   property p_spd1;
      (st_ff.in_sel[0] == FI_SPD1 && st_ff.in_lvl[0]) |=> DRIVE_CMD.speed_sel[1];
   endproperty
   a_spd1: assert property (p_spd1) else $error("speed bit 1 missing");

   property p_spd2;
      (st_ff.in_sel[0] == FI_SPD2 && st_ff.in_lvl[0]) |=> DRIVE_CMD.speed_sel[2];
   endproperty
   a_spd2: assert property (p_spd2) else $error("speed bit 2 missing");

   property p_fwd;
      (st_ff.in_sel[0] == FI_FWD && st_ff.in_lvl[0]) |=> DRIVE_CMD.run_fwd;
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward missing");

   property p_rev;
      (st_ff.in_sel[0] == FI_REV && st_ff.in_lvl[0]) |=> DRIVE_CMD.run_rev;
   endproperty
   a_rev: assert property (p_rev) else $error("reverse missing");

   property p_3wire;
      (st_ff.in_sel[0] == FI_3WIRE && st_ff.in_lvl[0]) |=> DRIVE_CMD.three_wire;
   endproperty
   a_3wire: assert property (p_3wire) else $error("three-wire missing");

   property p_frst;
      (st_ff.in_sel[0] == FI_RST && st_ff.in_lvl[0]) |=> DRIVE_CMD.fault_reset;
   endproperty
   a_frst: assert property (p_frst) else $error("fault reset missing");

   property p_extf;
      (st_ff.in_sel[0] == FI_EXTF && st_ff.in_lvl[0]) |=> DRIVE_CMD.ext_fault;
   endproperty
   a_extf: assert property (p_extf) else $error("external fault missing");

   property p_estop;
      (st_ff.in_sel[0] == FI_ESTOP && st_ff.in_lvl[0]) |=> DRIVE_CMD.emerg_stop;
   endproperty
   a_estop: assert property (p_estop) else $error("fast stop missing");

   property p_lrise;
      (st_ff.in_sel[0] == FI_LRISE && st_ff.in_lvl[0] && st_ff.run_mode == MODE_LIFT)
         |=> DRIVE_CMD.lift_rise;
   endproperty
   a_lrise: assert property (p_lrise) else $error("lift rise missing");

   property p_brake_fb;
      (st_ff.in_sel[0] == FI_BRAKE && st_ff.in_lvl[0]) |=> DRIVE_CMD.brake_fb;
   endproperty
   a_brake_fb: assert property (p_brake_fb) else $error("brake check missing");

   property p_inv_fwd;
      (st_ff.in_sel[0] == FI_FWD + INVERT_OFS && !st_ff.in_lvl[0]) |=> DRIVE_CMD.run_fwd;
   endproperty
   a_inv_fwd: assert property (p_inv_fwd) else $error("open forward missing");

   // filter: zero count passes at once, counter never runs past ten
   property p_filt_now;
      (st_ff.filter == 8'h00 && DIGITAL_INPUT[0] != st_ff.in_lvl[0])
         |=> st_ff.in_lvl[0] == $past(DIGITAL_INPUT[0]);
   endproperty
   a_filt_now: assert property (p_filt_now) else $error("unfiltered input held");

   property p_cnt_max;
      st_ff.flt_cnt[0] <= 4'hA;
   endproperty
   a_cnt_max: assert property (p_cnt_max) else $error("filter counter overrun");

   // output map: pin follows status one cycle later
   property p_ready_out;
      (st_ff.out_sel[0] == FO_READY)
         |=> RELAY_OUT[0] == ($past(DRIVE_STAT.self_test_ok) & !$past(DRIVE_STAT.fault));
   endproperty
   a_ready_out: assert property (p_ready_out) else $error("ready relay wrong");

   property p_fault_inv;
      (st_ff.out_sel[2] == FO_FAULT + INVERT_OFS)
         |=> OC_OUT_OE[0] == !$past(DRIVE_STAT.fault_stop);
   endproperty
   a_fault_inv: assert property (p_fault_inv) else $error("inverted fault wrong");

   property p_run_out;
      (st_ff.out_sel[0] == FO_RUN) |=> RELAY_OUT[0] == $past(DRIVE_STAT.running);
   endproperty
   a_run_out: assert property (p_run_out) else $error("run relay wrong");

   property p_zero_out;
      (st_ff.out_sel[2] == FO_ZERO)
         |=> OC_OUT_OE[0] == ($past(DRIVE_STAT.running) & $past(DRIVE_STAT.zero_power));
   endproperty
   a_zero_out: assert property (p_zero_out) else $error("zero power wrong");

   property p_bus_out;
      (st_ff.out_sel[0] == FO_BUSOK) |=> RELAY_OUT[0] == $past(DRIVE_STAT.bus_ok);
   endproperty
   a_bus_out: assert property (p_bus_out) else $error("bus relay wrong");

   property p_bus_inv;
      (st_ff.out_sel[2] == FO_BUSOK + INVERT_OFS) |=> OC_OUT_OE[0] == !$past(DRIVE_STAT.bus_ok);
   endproperty
   a_bus_inv: assert property (p_bus_inv) else $error("inverted bus wrong");

   property p_regen_out;
      (st_ff.out_sel[0] == FO_REGEN) |=> RELAY_OUT[0] == $past(DRIVE_STAT.regen);
   endproperty
   a_regen_out: assert property (p_regen_out) else $error("regen relay wrong");

   property p_regen_inv;
      (st_ff.out_sel[2] == FO_REGEN + INVERT_OFS) |=> OC_OUT_OE[0] == !$past(DRIVE_STAT.regen);
   endproperty
   a_regen_inv: assert property (p_regen_inv) else $error("inverted regen wrong");

   property p_anti_out;
      (st_ff.out_sel[0] == FO_ANTI) |=> RELAY_OUT[0] == $past(DRIVE_STAT.dir_cmd);
   endproperty
   a_anti_out: assert property (p_anti_out) else $error("anti-stick relay wrong");

   property p_lbrk_out;
      (st_ff.out_sel[0] == FO_LBRK) |=> RELAY_OUT[0] ==
         ($past(DRIVE_STAT.lift_brake_rel) && $past(st_ff.run_mode) == MODE_LIFT);
   endproperty
   a_lbrk_out: assert property (p_lbrk_out) else $error("lift brake wrong");

   property p_nbrk_out;
      (st_ff.out_sel[1] == FO_NBRK) |=> RELAY_OUT[1] ==
         ($past(DRIVE_STAT.norm_brake_rel) && $past(st_ff.run_mode) == MODE_NORMAL);
   endproperty
   a_nbrk_out: assert property (p_nbrk_out) else $error("normal brake wrong");

   property p_oc_off;
      (st_ff.out_sel[2] == 8'h00) |=> !OC_OUT_OE[0];
   endproperty
   a_oc_off: assert property (p_oc_off) else $error("unused collector driven");

   // main scenarios seen
   c_lift: cover property (@(posedge MCLK) disable iff (!RST_N) DRIVE_CMD.lift_rise);
   c_oc_on: cover property (@(posedge MCLK) disable iff (!RST_N) OC_OUT_OE[0]);
   c_fwd: cover property (@(posedge MCLK) disable iff (!RST_N) DRIVE_CMD.run_fwd);
   c_speed7: cover property (@(posedge MCLK) disable iff (!RST_N) DRIVE_CMD.speed_sel == 3'h7);
   c_brake: cover property (@(posedge MCLK) disable iff (!RST_N) RELAY_OUT[1]);
endmodule : dio_mapper

// ---- hw/dio_pkg.sv ----
// package of constants and types for the drive input/output function mapper
package dio_pkg;
   localparam int          NUM_IN         = 7;
   localparam int          NUM_OUT        = 6;
   // register byte offsets
   localparam logic [11:0] OFS_IN_SEL0    = 12'h000; // inputs 0..6 at +4 each
   localparam logic [11:0] OFS_FILTER     = 12'h020;
   localparam logic [11:0] OFS_OUT_SEL0   = 12'h024; // relay0, relay1, oc0..oc3
   localparam logic [11:0] OFS_RUN_MODE   = 12'h040;
   localparam logic [11:0] OFS_CMD_STAT   = 12'h044; // read-only decoded commands
   localparam logic [11:0] OFS_IN_STAT    = 12'h048; // read-only filtered inputs
   // reset values
   localparam logic [7:0]  RST_IN_SEL0    = 8'h03;
   localparam logic [7:0]  RST_IN_SEL1    = 8'h04;
   localparam logic [7:0]  RST_IN_SEL2    = 8'h05;
   localparam logic [7:0]  RST_IN_SEL3    = 8'h00;
   localparam logic [7:0]  RST_IN_SEL4    = 8'h76;
   localparam logic [7:0]  RST_IN_SEL5    = 8'h00;
   localparam logic [7:0]  RST_IN_SEL6    = 8'h07;
   localparam logic [7:0]  RST_FILTER     = 8'h04;
   localparam logic [7:0]  RST_OUT_SEL0   = 8'h02;
   localparam logic [7:0]  RST_OUT_SEL1   = 8'h1F;
   localparam logic [7:0]  RST_OUT_SELOC  = 8'h00;
   localparam logic [1:0]  RST_RUN_MODE   = 2'h0;
   localparam logic [7:0]  FILTER_MAX     = 8'h0A;
   localparam logic [7:0]  INVERT_OFS     = 8'h64; // 100 added inverts the sense
   localparam logic [1:0]  MODE_NORMAL    = 2'h1;
   localparam logic [1:0]  MODE_LIFT      = 2'h3;
   // input function codes
   localparam logic [7:0]  FI_RAMP0 = 8'h01;
   localparam logic [7:0]  FI_RAMP1 = 8'h02;
   localparam logic [7:0]  FI_SPD0  = 8'h03;
   localparam logic [7:0]  FI_SPD1  = 8'h04;
   localparam logic [7:0]  FI_SPD2  = 8'h05;
   localparam logic [7:0]  FI_FWD   = 8'h07;
   localparam logic [7:0]  FI_REV   = 8'h08;
   localparam logic [7:0]  FI_3WIRE = 8'h09;
   localparam logic [7:0]  FI_RST   = 8'h0D;
   localparam logic [7:0]  FI_EXTF  = 8'h0E;
   localparam logic [7:0]  FI_BLOCK = 8'h12;
   localparam logic [7:0]  FI_ESTOP = 8'h1D;
   localparam logic [7:0]  FI_LRISE = 8'h1E;
   localparam logic [7:0]  FI_LFALL = 8'h1F;
   localparam logic [7:0]  FI_BRAKE = 8'h20;
   // output function codes
   localparam logic [7:0]  FO_READY = 8'h01;
   localparam logic [7:0]  FO_FAULT = 8'h02;
   localparam logic [7:0]  FO_RUN   = 8'h03;
   localparam logic [7:0]  FO_ZERO  = 8'h06;
   localparam logic [7:0]  FO_BUSOK = 8'h07;
   localparam logic [7:0]  FO_REGEN = 8'h10;
   localparam logic [7:0]  FO_ANTI  = 8'h1D;
   localparam logic [7:0]  FO_LBRK  = 8'h1E;
   localparam logic [7:0]  FO_NBRK  = 8'h1F;

   // decoded drive commands
   typedef struct packed {
      logic [1:0] ramp_sel;
      logic [2:0] speed_sel;
      logic       run_fwd;
      logic       run_rev;
      logic       three_wire;
      logic       fault_reset;
      logic       ext_fault;
      logic       out_block;
      logic       emerg_stop;
      logic       lift_rise;
      logic       lift_fall;
      logic       brake_fb;
   } dio_cmd_t;

   // drive status feeding the outputs
   typedef struct packed {
      logic self_test_ok;
      logic fault;
      logic fault_stop;
      logic running;
      logic zero_power;
      logic bus_ok;
      logic regen;
      logic dir_cmd;
      logic lift_brake_rel;
      logic norm_brake_rel;
   } dio_stat_t;
endpackage : dio_pkg

// ---- tb/dio_field_model.sv ----
// field wiring model: switch contacts, drive status source and collector pins
`timescale 1ns/100ps
module dio_field_model
   import dio_pkg::*;
(
   input  wire logic              MCLK,
   input  wire logic [NUM_IN-1:0] SW_REQ,
   input  wire dio_stat_t         STAT_REQ,
   input  wire logic [3:0]        OC_OUT_O,
   input  wire logic [3:0]        OC_OUT_OE,
   output logic      [NUM_IN-1:0] DIGITAL_INPUT = '0,
   output dio_stat_t              DRIVE_STAT = '0,
   output logic      [3:0]        OC_PIN
);
   // contacts and drive status settle just after a clock edge
   always @(posedge MCLK) begin
      DIGITAL_INPUT <= SW_REQ;
      DRIVE_STAT    <= STAT_REQ;
   end
   // external pull-up: the pin is low only while the collector is driven
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         OC_PIN[i] = OC_OUT_OE[i] ? OC_OUT_O[i] : 1'b1;
      end
   end
endmodule : dio_field_model

// ---- tb/dio_mapper_tb_top.sv ----
// self-checking bench for the drive input/output function mapper
`timescale 1ns/100ps
module dio_mapper_tb_top
   import dio_pkg::*;
;
   logic              mclk = 1'b0;
   logic              rst_n = 1'b0;
   logic [11:0]       paddr = 12'h000;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [31:0]       pwdata = 32'h00000000;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [NUM_IN-1:0] sw_req = '0;
   dio_stat_t         stat_req = '0;
   logic [NUM_IN-1:0] din;
   dio_stat_t         dstat;
   dio_cmd_t          dcmd;
   logic [1:0]        relay;
   logic [3:0]        oc_o;
   logic [3:0]        oc_oe;
   logic [3:0]        oc_pin;
   logic [31:0]       rd;
   logic              er;
   logic [7:0]        code;
   logic              e;
   int                err_total = 0;
   int                checked = 0;
   logic [7:0]        rst_tab [0:13];
   logic [7:0]        ci [0:14];
   logic [7:0]        co [0:9];
   logic [9:0]        st [0:4];

   dio_mapper dut (.MCLK(mclk), .RST_N(rst_n), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .DIGITAL_INPUT(din), .DRIVE_STAT(dstat), .DRIVE_CMD(dcmd), .RELAY_OUT(relay),
      .OC_OUT_O(oc_o), .OC_OUT_OE(oc_oe));
   dio_field_model u_field (.MCLK(mclk), .SW_REQ(sw_req), .STAT_REQ(stat_req), .OC_OUT_O(oc_o),
      .OC_OUT_OE(oc_oe), .DIGITAL_INPUT(din), .DRIVE_STAT(dstat), .OC_PIN(oc_pin));

   // 125 MHz clock
   initial begin
      forever #4 mclk = ~mclk;
   end

   // one apb transfer; read data and error taken at the completing edge
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel   <= 1'b1;
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_total++;
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      if (err_total == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test

   // expected commands for one input with code c, a = function active
   function automatic dio_cmd_t exp_cmd(input logic [7:0] c, input logic a, input logic [1:0] m);
      dio_cmd_t x;
      x = '0;
      case (c >= INVERT_OFS ? c - INVERT_OFS : c)
         FI_RAMP0: x.ramp_sel[0]  = a;
         FI_RAMP1: x.ramp_sel[1]  = a;
         FI_SPD0:  x.speed_sel[0] = a;
         FI_SPD1:  x.speed_sel[1] = a;
         FI_SPD2:  x.speed_sel[2] = a;
         FI_FWD:   x.run_fwd      = a;
         FI_REV:   x.run_rev      = a;
         FI_3WIRE: x.three_wire   = a;
         FI_RST:   x.fault_reset  = a;
         FI_EXTF:  x.ext_fault    = a;
         FI_BLOCK: x.out_block    = a;
         FI_ESTOP: x.emerg_stop   = a;
         FI_LRISE: x.lift_rise    = a & (m == MODE_LIFT);
         FI_LFALL: x.lift_fall    = a & (m == MODE_LIFT);
         FI_BRAKE: x.brake_fb     = a;
         default:  x = '0;
      endcase
      return x;
   endfunction : exp_cmd

   // expected asserted state of an output with code c
   function automatic logic exp_out(input logic [7:0] c, input dio_stat_t s, input logic [1:0] m);
      logic v;
      case (c >= INVERT_OFS ? c - INVERT_OFS : c)
         FO_READY: v = s.self_test_ok & ~s.fault;
         FO_FAULT: v = s.fault_stop;
         FO_RUN:   v = s.running;
         FO_ZERO:  v = s.running & s.zero_power;
         FO_BUSOK: v = s.bus_ok;
         FO_REGEN: v = s.regen;
         FO_ANTI:  v = s.dir_cmd;
         FO_LBRK:  v = s.lift_brake_rel & (m == MODE_LIFT);
         FO_NBRK:  v = s.norm_brake_rel & (m == MODE_NORMAL);
         default:  v = 1'b0;
      endcase
      return (c >= INVERT_OFS) ? ~v : v;
   endfunction : exp_out

   // main sequence
   initial begin
      rst_tab = '{RST_IN_SEL0, RST_IN_SEL1, RST_IN_SEL2, RST_IN_SEL3, RST_IN_SEL4, RST_IN_SEL5,
                  RST_IN_SEL6, RST_FILTER, RST_OUT_SEL0, RST_OUT_SEL1, RST_OUT_SELOC,
                  RST_OUT_SELOC, RST_OUT_SELOC, RST_OUT_SELOC};
      ci = '{FI_RAMP0, FI_RAMP1, FI_SPD0, FI_SPD1, FI_SPD2, FI_FWD, FI_REV, FI_3WIRE, FI_RST,
             FI_EXTF, FI_BLOCK, FI_ESTOP, FI_LRISE, FI_LFALL, FI_BRAKE};
      co = '{8'h00, FO_READY, FO_FAULT, FO_RUN, FO_ZERO, FO_BUSOK, FO_REGEN, FO_ANTI, FO_LBRK,
             FO_NBRK};
      st = '{10'h3FF, 10'h000, 10'h155, 10'h2AA, 10'h1FF};
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (10) @(posedge mclk);
      chk({17'h00000, dcmd}, {17'h00000, exp_cmd(RST_IN_SEL4, 1'b1, RST_RUN_MODE)});
      // reset values, then unmapped hole and filter clamp
      for (int i = 0; i < 14; i++) begin
         apb(12'(4 * i) + (i > 6 ? 12'h004 : 12'h000), 1'b0, 32'h00000000);
         chk(rd, {24'h000000, rst_tab[i]});
      end
      apb(12'h01C, 1'b1, 32'h000000FF);
      chk({31'h00000000, er}, 32'h00000001);
      apb(12'h01C, 1'b0, 32'h00000000);
      chk(rd, 32'h00000000);
      apb(OFS_FILTER, 1'b1, 32'h000000FF);
      apb(OFS_FILTER, 1'b0, 32'h00000000);
      chk(rd, {24'h000000, FILTER_MAX});
      // filter of 3: a short pulse is dropped, a held level passes
      apb(OFS_FILTER, 1'b1, 32'h00000003);
      for (int i = 0; i < 7; i++) apb(12'(4 * i), 1'b1, 32'h00000000);
      apb(OFS_IN_SEL0, 1'b1, {24'h000000, FI_FWD});
      sw_req[0] <= 1'b1;
      repeat (3) @(posedge mclk);
      sw_req[0] <= 1'b0;
      repeat (12) @(posedge mclk);
      chk({31'h00000000, dcmd.run_fwd}, 32'h00000000);
      sw_req[0] <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({31'h00000000, dcmd.run_fwd}, 32'h00000000);
      repeat (12) if (dcmd.run_fwd !== 1'b1) @(posedge mclk);
      chk({31'h00000000, dcmd.run_fwd}, 32'h00000001);
      apb(OFS_FILTER, 1'b1, 32'h00000000);
      // every input code, plain and inverted, both levels, two run modes
      for (int m = 0; m < 4; m += 3) begin
         apb(OFS_RUN_MODE, 1'b1, 32'(m));
         apb(OFS_RUN_MODE, 1'b0, 32'h00000000);
         chk(rd, 32'(m));
         for (int i = 0; i < 30; i++) begin
            code = ci[i % 15] + (i > 14 ? INVERT_OFS : 8'h00);
            apb(OFS_IN_SEL0, 1'b1, {24'h000000, code});
            for (int l = 0; l < 2; l++) begin
               sw_req[0] <= l[0];
               repeat (8) @(posedge mclk);
               chk({17'h00000, dcmd}, {17'h00000, exp_cmd(code, l[0] ^ (i > 14), 2'(m))});
               apb(OFS_CMD_STAT, 1'b0, 32'h00000000);
               chk(rd, {17'h00000, exp_cmd(code, l[0] ^ (i > 14), 2'(m))});
               apb(OFS_IN_STAT, 1'b0, 32'h00000000);
               chk(rd, {25'h0000000, 6'h00, l[0]});
            end
         end
      end
      apb(OFS_IN_SEL0, 1'b1, 32'h00000000);
      // every output code on both relays and all four collectors against status patterns
      for (int i = 0; i < 19; i++) begin
         code = (i < 10) ? co[i] : co[i - 9] + INVERT_OFS;
         for (int j = 0; j < 6; j++) apb(OFS_OUT_SEL0 + 12'(4 * j), 1'b1, {24'h000000, code});
         for (int m = 1; m < 4; m += 2) begin
            apb(OFS_RUN_MODE, 1'b1, 32'(m));
            for (int s = 0; s < 5; s++) begin
               stat_req <= st[s];
               repeat (4) @(posedge mclk);
               e = exp_out(code, st[s], 2'(m));
               chk({30'h00000000, relay}, {30'h00000000, {2{e}}});
               chk({28'h0000000, oc_oe}, {28'h0000000, {4{e}}});
               chk({28'h0000000, oc_o}, 32'h00000000);
               chk({28'h0000000, oc_pin}, {28'h0000000, {4{~e}}});
            end
         end
      end
      stop_test();
   end

   // watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      stop_test();
   end
endmodule : dio_mapper_tb_top
